// ### aprr_far_model.sv
// Far side model: digital receiver pair and processor return pairs.
// Assumes the processor refreshes its outputs once per frame on ref_clk.
// No output port runs as a clock slave here, so high speed slave mode stays off.
`timescale 1ns/1ps
module aprr_far_model import aprr_pkg::*; (
    input  logic                           ref_clk,
    input  logic                           rst,
    input  logic                           frameTick,
    output aprr_pair_t                     rxPair,
    output aprr_pair_t [NUM_RET_PAIRS-1:0] dspReturn
);
    // Core side is synchronous, so its pairs move only on a frame boundary
    always @(posedge ref_clk)
        if (rst || frameTick)
        begin
            rxPair <= 48'({$urandom, $urandom});
            for (int i = 0; i < NUM_RET_PAIRS; i++)
                dspReturn[i] <= 48'({$urandom, $urandom});
        end
endmodule : aprr_far_model

// ### aprr_input_router.sv
// Input side of the audio routing fabric: channel packing, processor feed, pair crossbar.
// Assumes port slots, modes, selectors and frame strobes come from logic on ref_clk.
// Assumes the converters and the core take convIn and dspIn on ref_clk as well.
// Selectors are plain inputs; whoever owns them keeps every link one-to-one.
`timescale 1ns/1ps
module aprr_input_router (
    input  wire logic                                              ref_clk,
    input  wire logic                                              rst,
    input  wire aprr_pkg::aprr_variant_t                           variant,
    input  wire aprr_pkg::aprr_mode_t [aprr_pkg::NUM_PORTS-1:0]    portMode,
    input  wire aprr_pkg::aprr_slot_t [aprr_pkg::NUM_PORTS-1:0]    portSlot,
    input  wire logic                                              frameTick,
    input  wire aprr_pkg::aprr_pair_t                              rxPair,
    input  wire aprr_pkg::aprr_pair_t [aprr_pkg::NUM_RET_PAIRS-1:0] dspReturn,
    input  wire logic [aprr_pkg::NUM_CONV-1:0]                     convFrame,
    input  wire logic [aprr_pkg::NUM_CONV-1:0][aprr_pkg::SEL_W-1:0] convSelect,
    output      aprr_pkg::aprr_sample_t [aprr_pkg::NUM_CHAN-1:0]   dspIn,
    output      aprr_pkg::aprr_pair_t [aprr_pkg::NUM_CONV-1:0]     convIn,
    output      logic [aprr_pkg::NUM_CONV-1:0]                     convSelBad
);
    import aprr_pkg::*;

    // Block size per mode; an idle port still costs its whole block
    function automatic logic [BASE_W-1:0] chanCount(input aprr_mode_t mode);
        case (mode)
            MODE_TWO_CHAN:     chanCount = CNT_TWO;
            MODE_FOUR_SLOT:    chanCount = CNT_FOUR;
            MODE_PACKED_FOUR:  chanCount = CNT_FOUR;
            MODE_EIGHT_SLOT:   chanCount = CNT_EIGHT;
            MODE_SIXTEEN_SLOT: chanCount = CNT_SIXTEEN;
            default:           chanCount = CNT_TWO;
        endcase
    endfunction : chanCount

    // Live bank, its next value, and the frame-delayed copies feeding the core
    aprr_sample_t [NUM_CHAN-1:0]  bank_q;
    aprr_sample_t [NUM_CHAN-1:0]  bank_d;
    aprr_sample_t [NUM_CHAN-1:0]  stage_q [PASS_FRAMES];
    aprr_pair_t [NUM_SRC-1:0]     srcPairs;
    aprr_pair_t [NUM_CONV-1:0]    muxPair;
    aprr_pair_t [NUM_CONV-1:0]    convIn_q;
    logic [NUM_CONV-1:0]          muxValid;
    logic [NUM_CONV-1:0]          convApply;
    logic [NUM_CONV-1:0]          convSelBad_q;
    logic [NUM_CONV-1:0]          selBad;
    logic [NUM_CONV-1:0]          convLoad;
    logic [NUM_CONV-1:0]          flagNext;
    aprr_pair_t [NUM_CONV-1:0]    pairNext;
    aprr_sample_t [NUM_CHAN-1:0]  stageIn [PASS_FRAMES];
    logic [BASE_W-1:0]            portBase [NUM_PORTS+1];
    logic [BASE_W-1:0]            portCount [NUM_PORTS];
    logic [BASE_W-1:0]            chanIdx [NUM_PORTS];
    logic [BASE_W-1:0]            slotIdx [NUM_PORTS];
    logic [NUM_PORTS-1:0]         slotHit;
    wire                          convActive = (variant != VAR_NO_CONVERTER);

    // Channel packing: port blocks laid end to end in port order
    assign portBase[0] = '0;
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++)
        begin : g_port
            assign portCount[gp]  = chanCount(portMode[gp]);
            // Nine ports of sixteen slots sum to 144 at most, so eight bits never wrap
            assign portBase[gp+1] = BASE_W'(portBase[gp] + portCount[gp]);
            assign slotIdx[gp]    = BASE_W'(portSlot[gp].slot);
            assign chanIdx[gp]    = BASE_W'(portBase[gp] + slotIdx[gp]);
            // Slots beyond the mode's count or past channel 23 are dropped
            assign slotHit[gp]    = portSlot[gp].valid
                                    && (slotIdx[gp] < portCount[gp])
                                    && (chanIdx[gp] < BASE_W'(NUM_CHAN));
        end
    endgenerate

    // Later ports overwrite earlier ones, so the highest port wins a channel collision
    always_comb
    begin
        bank_d = bank_q;
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            if (slotHit[p])
            begin
                bank_d[chanIdx[p][IDX_W-1:0]] = portSlot[p].data;
            end
        end
    end

    // One register per channel; a channel only moves when a slot for it lands
    genvar gch;
    generate
        for (gch = 0; gch < NUM_CHAN; gch++)
        begin : g_chan
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    bank_q[gch] <= SAMPLE_RESET;
                end
                else
                begin
                    bank_q[gch] <= bank_d[gch];
                end
            end
        end
    endgenerate

    // Processor feed waits out whole frames so passthrough is never faster than the floor
    // Four full banks of registers buy a latency floor that holds in every port mode
    genvar gf;
    generate
        for (gf = 0; gf < PASS_FRAMES; gf++)
        begin : g_frame
            if (gf == 0)
            begin : g_head
                assign stageIn[gf] = bank_q;
            end
            else
            begin : g_tail
                assign stageIn[gf] = stage_q[gf-1];
            end

            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    stage_q[gf] <= '0;
                end
                else if (frameTick)
                begin
                    stage_q[gf] <= stageIn[gf];
                end
            end
        end
    endgenerate

    assign dspIn = stage_q[PASS_FRAMES-1];

    // Source list: 12 input pairs, receiver pair, 8 processor return pairs
    // Sources read the live bank, one cycle after a slot lands, not the delayed feed
    genvar gs;
    generate
        for (gs = 0; gs < NUM_IN_PAIRS; gs++)
        begin : g_in_src
            assign srcPairs[SRC_IN_FIRST + gs] = {bank_q[2*gs], bank_q[2*gs+1]};
        end
        for (gs = 0; gs < NUM_RET_PAIRS; gs++)
        begin : g_ret_src
            assign srcPairs[SRC_RET_FIRST + gs] = dspReturn[gs];
        end
    endgenerate
    assign srcPairs[SRC_RX_IDX] = rxPair;

    genvar gc;
    generate
        for (gc = 0; gc < NUM_CONV; gc++)
        begin : g_conv
            // Octal converters: a whole group follows its first member's boundary
            // so the four pairs of one converter never straddle two source frames
            assign convApply[gc] = (variant == VAR_TWO_OCTAL)
                                   ? convFrame[(gc / GROUP_SIZE) * GROUP_SIZE]
                                   : convFrame[gc];

            aprr_pair_mux u_mux (
                .srcPairs (srcPairs),
                .sel      (convSelect[gc][IDX_W-1:0]),
                .selPair  (muxPair[gc]),
                .selValid (muxValid[gc])
            );

            // Any selector outside 0..20, upper bits included, routes silence, never a pair
            assign selBad[gc]   = !muxValid[gc] || (convSelect[gc][SEL_W-1:IDX_W] != '0);
            // No converters fitted: the crossbar idles at zero every cycle
            assign convLoad[gc] = !convActive || convApply[gc];
            assign pairNext[gc] = (!convActive || selBad[gc]) ? '0 : muxPair[gc];
            assign flagNext[gc] = convActive && selBad[gc];

            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    convIn_q[gc] <= '0;
                end
                else if (convLoad[gc])
                begin
                    convIn_q[gc] <= pairNext[gc];
                end
            end

            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    convSelBad_q[gc] <= 1'b0;
                end
                else if (convLoad[gc])
                begin
                    convSelBad_q[gc] <= flagNext[gc];
                end
            end
        end
    endgenerate

    assign convIn     = convIn_q;
    assign convSelBad = convSelBad_q;

endmodule : aprr_input_router

// ### aprr_input_router_monitor.sv
// Checker on the input router ports: crossbar timing, selector checks, processor feed.
// Assumes one clock, ref_clk, and an active high reset.
`timescale 1ns/1ps
module aprr_input_router_monitor import aprr_pkg::*; (
    input logic                           ref_clk,
    input logic                           rst,
    input aprr_variant_t                  variant,
    input aprr_mode_t [NUM_PORTS-1:0]     portMode,
    input aprr_slot_t [NUM_PORTS-1:0]     portSlot,
    input logic                           frameTick,
    input aprr_pair_t                     rxPair,
    input aprr_pair_t [NUM_RET_PAIRS-1:0] dspReturn,
    input logic [NUM_CONV-1:0]            convFrame,
    input logic [NUM_CONV-1:0][SEL_W-1:0] convSelect,
    input aprr_sample_t [NUM_CHAN-1:0]    dspIn,
    input aprr_pair_t [NUM_CONV-1:0]      convIn,
    input logic [NUM_CONV-1:0]            convSelBad
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    noconv_zero_a: assert property (
        variant == VAR_NO_CONVERTER |=> convIn == '0 && convSelBad == '0)
        else $error("converter pairs not cleared");
    rx_route_a: assert property (
        variant == VAR_EIGHT_STEREO && convFrame[4] && convSelect[4] == 16'h000C
        |=> convIn[4] == $past(rxPair))
        else $error("receiver pair not routed");
    ret_route_a: assert property (
        variant == VAR_EIGHT_STEREO && convFrame[4] && convSelect[4] == 16'h0014
        |=> convIn[4] == $past(dspReturn[7]))
        else $error("return pair not routed");
    bad_sel_a: assert property (
        variant == VAR_EIGHT_STEREO && convFrame[5] && convSelect[5] > 16'h0014
        |=> convSelBad[5] && convIn[5] == '0)
        else $error("bad selector accepted");
    good_sel_a: assert property (
        variant == VAR_EIGHT_STEREO && convFrame[5] && convSelect[5] <= 16'h0014
        |=> !convSelBad[5])
        else $error("good selector flagged");
    pair_hold_a: assert property (
        variant == VAR_EIGHT_STEREO && !convFrame[1] |=> $stable(convIn[1]))
        else $error("pair changed off its boundary");
    flag_hold_a: assert property (
        variant == VAR_EIGHT_STEREO && !convFrame[2] |=> $stable(convSelBad[2]))
        else $error("flag changed off its boundary");
    feed_hold_a: assert property (
        !frameTick |=> $stable(dspIn))
        else $error("processor feed moved without a frame");
    group_apply_a: assert property (
        variant == VAR_TWO_OCTAL && convFrame[0] && convSelect[3] == 16'h000D
        |=> convIn[3] == $past(dspReturn[0]))
        else $error("group pair not applied");
endmodule : aprr_input_router_monitor

bind aprr_input_router aprr_input_router_monitor mon (.ref_clk, .rst, .variant, .portMode,
    .portSlot, .frameTick, .rxPair, .dspReturn, .convFrame, .convSelect, .dspIn, .convIn,
    .convSelBad);

// ### aprr_pair_mux.sv
// One output of the audio pair crossbar: picks one of the source pairs by index.
// Assumes the caller registers the result on its own sample boundary.
`timescale 1ns/1ps
module aprr_pair_mux (
    input  wire aprr_pkg::aprr_pair_t [aprr_pkg::NUM_SRC-1:0] srcPairs,
    input  wire logic [aprr_pkg::IDX_W-1:0]                   sel,
    output      aprr_pkg::aprr_pair_t                         selPair,
    output      logic                                         selValid
);
    import aprr_pkg::*;

    // Whole pairs only, never a lone channel
    assign selValid = (sel <= SRC_LAST);
    assign selPair  = selValid ? srcPairs[sel] : '0;

endmodule : aprr_pair_mux

// ### aprr_pkg.sv
// Shared constants and carrier types for the input-side audio pair routing block.
// Assumes one core clock; every neighbour block sits on that same clock.
package aprr_pkg;

    localparam int SAMPLE_W      = 24;
    localparam int NUM_PORTS     = 9;
    localparam int NUM_CHAN      = 24;
    localparam int NUM_IN_PAIRS  = 12;
    localparam int NUM_RET_PAIRS = 8;
    localparam int NUM_SRC       = 21;
    localparam int NUM_CONV      = 8;
    localparam int GROUP_SIZE    = 4;
    localparam int SEL_W         = 16;
    localparam int IDX_W         = 5;
    localparam int BASE_W        = 8;
    localparam int SLOT_W        = 4;
    localparam int PASS_FRAMES   = 4;

    // Source index layout of the pair crossbar
    localparam logic [IDX_W-1:0] SRC_IN_FIRST  = 5'h00;
    localparam logic [IDX_W-1:0] SRC_RX_IDX    = 5'h0C;
    localparam logic [IDX_W-1:0] SRC_RET_FIRST = 5'h0D;
    localparam logic [IDX_W-1:0] SRC_LAST      = 5'h14;

    // Channel counts per port mode
    localparam logic [BASE_W-1:0] CNT_TWO     = 8'h02;
    localparam logic [BASE_W-1:0] CNT_FOUR    = 8'h04;
    localparam logic [BASE_W-1:0] CNT_EIGHT   = 8'h08;
    localparam logic [BASE_W-1:0] CNT_SIXTEEN = 8'h10;

    typedef logic [SAMPLE_W-1:0] aprr_sample_t;

    typedef struct packed {
        aprr_sample_t left;
        aprr_sample_t right;
    } aprr_pair_t;

    // One received channel slot from a serial input port
    typedef struct packed {
        logic              valid;
        logic [SLOT_W-1:0] slot;
        aprr_sample_t      data;
    } aprr_slot_t;

    typedef enum logic [2:0] {
        MODE_TWO_CHAN     = 3'h0,
        MODE_FOUR_SLOT    = 3'h1,
        MODE_EIGHT_SLOT   = 3'h2,
        MODE_SIXTEEN_SLOT = 3'h3,
        MODE_PACKED_FOUR  = 3'h4
    } aprr_mode_t;

    // Gray coded along the usual order
    typedef enum logic [1:0] {
        VAR_EIGHT_STEREO = 2'h0,
        VAR_TWO_OCTAL    = 2'h1,
        VAR_NO_CONVERTER = 2'h3
    } aprr_variant_t;

    localparam aprr_sample_t SAMPLE_RESET = 24'h00_0000;
    localparam logic [IDX_W-1:0] SEL_RESET = 5'h00;

endpackage : aprr_pkg

// ### test_aprr_input_router.sv
// Self-checking bench for the input router: packing, processor feed, pair crossbar.
// Assumes the far side model supplies receiver and processor return pairs.
`timescale 1ns/1ps
module test_aprr_input_router;
    import aprr_pkg::*;
    typedef struct { aprr_pair_t p; logic b; } aprr_exp_t;
    logic                           ref_clk = 0, rst = 1, frameTick = 0, tk;
    aprr_variant_t                  variant = VAR_EIGHT_STEREO;
    aprr_mode_t [NUM_PORTS-1:0]     portMode = '{MODE_TWO_CHAN, MODE_TWO_CHAN, MODE_SIXTEEN_SLOT,
        MODE_TWO_CHAN, MODE_PACKED_FOUR, MODE_TWO_CHAN, MODE_FOUR_SLOT, MODE_EIGHT_SLOT,
        MODE_TWO_CHAN};
    aprr_slot_t [NUM_PORTS-1:0]     portSlot = '0;
    aprr_pair_t                     rxPair;
    aprr_pair_t [NUM_RET_PAIRS-1:0] dspReturn;
    logic [NUM_CONV-1:0]            convFrame = '0, convSelBad, m;
    logic [NUM_CONV-1:0][SEL_W-1:0] convSelect = '0;
    aprr_sample_t [NUM_CHAN-1:0]    dspIn, ch = '0;
    aprr_pair_t [NUM_CONV-1:0]      convIn;
    aprr_exp_t                      q[$];
    aprr_sample_t [NUM_CHAN-1:0]    dq[$];
    logic [SEL_W-1:0]               bad[3] = '{16'h0015, 16'h001F, 16'h0100};
    int                             fails = 0, comparisons = 0, b;

    aprr_input_router uut (.ref_clk, .rst, .variant, .portMode, .portSlot, .frameTick, .rxPair,
        .dspReturn, .convFrame, .convSelect, .dspIn, .convIn, .convSelBad);
    aprr_far_model far (.ref_clk, .rst, .frameTick, .rxPair, .dspReturn);

    initial forever #5 ref_clk = ~ref_clk;

    task automatic step(int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    function automatic int cnt(aprr_mode_t md);
        case (md)
            MODE_TWO_CHAN:     return 2;
            MODE_EIGHT_SLOT:   return 8;
            MODE_SIXTEEN_SLOT: return 16;
            default:           return 4;
        endcase
    endfunction : cnt

    function automatic aprr_exp_t pick(logic [SEL_W-1:0] s);
        aprr_exp_t e;
        e.p = '0;
        e.b = 1'b0;
        if (s < 12) e.p = {ch[2*s], ch[2*s+1]};
        else if (s == 12) e.p = rxPair;
        else if (s <= 20) e.p = dspReturn[s-13];
        else e.b = 1'b1;
        return e;
    endfunction : pick

    task automatic cmpPair(aprr_pair_t g, logic gb, aprr_exp_t e);
        comparisons++;
        if (g !== e.p || gb !== e.b)
        begin
            fails++;
            $display("wrong value at %0t: pair %h/%b, expected %h/%b", $time, g, gb, e.p, e.b);
        end
    endtask : cmpPair

    task automatic cmpChan(aprr_sample_t [NUM_CHAN-1:0] g, aprr_sample_t [NUM_CHAN-1:0] e);
        comparisons++;
        if (g !== e)
        begin
            fails++;
            $display("wrong value at %0t: processor feed %h, expected %h", $time, g, e);
        end
    endtask : cmpChan

    // Pulses one boundary; w pairs starting at n take their selectors on it
    task automatic route(int n, logic [SEL_W-1:0] s, int w = 1);
        convSelect[n] = s;
        convFrame[n] = 1'b1;
        // Without converters nothing is applied, so nothing is queued
        if (variant != VAR_NO_CONVERTER)
            for (int k = n; k < n + w; k++) q.push_back(pick(convSelect[k]));
        step();
        convFrame[n] = 1'b0;
        step();
    endtask : route

    task automatic print_verdict();
        $display("comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    always @(posedge ref_clk)
    begin
        m = (variant == VAR_TWO_OCTAL) ? {{4{convFrame[4]}}, {4{convFrame[0]}}} :
            (variant == VAR_EIGHT_STEREO) ? convFrame : '0;
        tk = frameTick;
        #2;
        for (int n = 0; n < NUM_CONV; n++)
            if (m[n] && q.size() > 0) cmpPair(convIn[n], convSelBad[n], q.pop_front());
        if (tk && dq.size() > 0) cmpChan(dspIn, dq.pop_front());
    end

    // Whole run is under two hundred cycles
    initial
    begin
        #20000;
        fails++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(36));
        repeat (12) @(posedge ref_clk);
        #1 rst = 0;
        step(2);
        b = 0;
        // Slot one past each block except the sixteen-slot one, and all of ports past the bank, must be dropped
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            for (int s = 0; s <= cnt(portMode[p]) && s < 16; s++)
            begin
                portSlot[p] = '{1'b1, 4'(s), SAMPLE_W'($urandom)};
                if (s < cnt(portMode[p]) && b + s < NUM_CHAN) ch[b+s] = portSlot[p].data;
                step();
            end
            portSlot[p].valid = 1'b0;
            b += cnt(portMode[p]);
        end
        for (int s = 0; s < NUM_SRC; s++) route(s % NUM_CONV, SEL_W'(s));
        foreach (bad[i]) route(5, bad[i]);
        route(5, 16'h000C);
        $display("packing and crossbar test done");
        variant = VAR_TWO_OCTAL;
        for (int n = 0; n < NUM_CONV; n++) convSelect[n] = SEL_W'(n < 4 ? 16 - n : n - 4);
        route(0, convSelect[0], 4);
        route(4, convSelect[4], 4);
        variant = VAR_NO_CONVERTER;
        route(0, 16'h000C);
        cmpPair(convIn[0], convSelBad[0], '{'0, 1'b0});
        $display("variant test done");
        variant = VAR_EIGHT_STEREO;
        repeat (3)
        begin
            frameTick = 1'b1;
            step();
            frameTick = 1'b0;
            step();
        end
        cmpChan(dspIn, '0);
        dq.push_back(ch);
        frameTick = 1'b1;
        step();
        frameTick = 1'b0;
        step(3);
        $display("processor feed test done");
        if (q.size() != 0 || dq.size() != 0) fails++;
        print_verdict();
    end
endmodule : test_aprr_input_router
